/* fpisc_pkg.sv */
// constants, types and state codes for the flash command interpreter
package fpisc_pkg;
   // status codes answered in status frames
   localparam logic [7:0] ST_ACK    = 8'h06;
   localparam logic [7:0] ST_CMDERR = 8'h04;
   localparam logic [7:0] ST_PARAM  = 8'h05;
   localparam logic [7:0] ST_SUMERR = 8'h07;
   localparam logic [7:0] ST_PROT   = 8'h10;
   localparam logic [7:0] ST_NACK   = 8'h15;
   localparam logic [7:0] ST_ERASE  = 8'h1A;
   localparam logic [7:0] ST_VERIFY = 8'h1B;
   localparam logic [7:0] ST_WRITE  = 8'h1C;
   // command codes (values arbitrary)
   localparam logic [7:0] CMD_STATUS   = 8'h70;
   localparam logic [7:0] CMD_VERSION  = 8'hC5;
   localparam logic [7:0] CMD_CHECKSUM = 8'hB0;
   localparam logic [7:0] CMD_SECURITY = 8'hA0;
   // flash geometry and security fields
   localparam int         BLK_BITS    = 11;
   localparam logic [7:0] LAST_BLOCK  = 8'h7F;
   localparam logic [7:0] FLG_FORCED  = 8'hE0;
   localparam int         BOOT_WR_BIT = 4;
   localparam logic [7:0] FLG_RESET   = 8'hFF;
   localparam logic [7:0] BOOT_RESET  = 8'h00;
   localparam logic [2:0] VER_LEN     = 3'h4;
   localparam logic [2:0] SUM_LEN     = 3'h2;
   // register byte offsets
   localparam logic [7:0] REG_CTRL    = 8'h00;
   localparam logic [7:0] REG_IRQ     = 8'h04;
   localparam logic [7:0] REG_MASK    = 8'h08;
   localparam logic [7:0] REG_VERSION = 8'h0C;
   localparam logic [7:0] REG_SECST   = 8'h10;
   localparam logic [7:0] REG_LAST    = 8'h14;
   // interrupt bit positions
   localparam int IRQ_ACK  = 0;
   localparam int IRQ_ERR  = 1;
   localparam int IRQ_SECW = 2;
   localparam logic [31:0] VERSION_RESET = 32'h0000_0000;
   // security write time-out
   localparam int SEC_WR_TIMEOUT_MS = 100;
   localparam int CLK_KHZ           = 25000;
   localparam int SEC_WR_CYC        = SEC_WR_TIMEOUT_MS * CLK_KHZ;

   // one received frame from the frame decoder
   typedef struct packed {
      logic            is_cmd;
      logic [7:0]      code;
      logic            len_ok;
      logic            etx_ok;
      logic            sum_ok;
      logic [5:0][7:0] prm;
   } fpisc_rx_t;

   // one data frame to the frame encoder
   typedef struct packed {
      logic [2:0]      len;
      logic [5:0][7:0] pld;
   } fpisc_txd_t;

   typedef enum logic [2:0] {
      S_IDLE     = 3'b000,
      S_VER_DATA = 3'b001,
      S_CSUM_RUN = 3'b010,
      S_CSUM_TL  = 3'b011,
      S_CSUM_TX  = 3'b100,
      S_SEC_WAIT = 3'b101,
      S_SEC_WR   = 3'b110
   } fpisc_state_t;
endpackage

/* fpisc_top.sv */
// device-side interpreter for version, checksum and security commands
`timescale 1ns/10ps
module fpisc_top #(
   parameter int unsigned SEC_WR_CYC = fpisc_pkg::SEC_WR_CYC
) (
   input  wire logic                 core_clk_i,
   input  wire logic                 reset_i,
   input  wire logic [7:0]           addr_i,
   input  wire logic [31:0]          wdata_i,
   input  wire logic                 wr_i,
   input  wire logic                 rd_i,
   output logic      [31:0]          rdata_o,
   output logic                      irq_o,
   input  wire logic                 rx_valid_i,
   input  wire fpisc_pkg::fpisc_rx_t rx_frame_i,
   output logic                      tx_stat_valid_o,
   output logic      [7:0]           tx_stat_code_o,
   output logic                      tx_data_valid_o,
   output fpisc_pkg::fpisc_txd_t     tx_data_o,
   output logic                      fl_rd_o,
   output logic      [23:0]          fl_addr_o,
   input  wire logic [7:0]           fl_rdata_i,
   output logic                      sec_wr_o,
   output logic      [7:0]           sec_flg_o,
   output logic      [7:0]           sec_boot_o,
   input  wire logic                 sec_done_i,
   input  wire logic [1:0]           sec_fault_i
);
   fpisc_pkg::fpisc_state_t state;
   fpisc_pkg::fpisc_state_t next_state;
   logic        enable;
   logic [2:0]  irq_stat;
   logic [2:0]  irq_mask;
   logic [31:0] version;
   logic [7:0]  cur_flg;
   logic [7:0]  cur_boot;
   logic [7:0]  last_code;
   logic [23:0] end_addr;
   logic [15:0] sum;
   logic        rd_pend;
   logic [31:0] timer;
   logic        next_st_valid;
   logic [7:0]  next_st_code;
   logic        next_sec_wr;
   logic        next_csum_go;
   logic        sec_ok;
   // frame classification
   wire cmd_in    = rx_valid_i & rx_frame_i.is_cmd & enable;
   wire dat_in    = rx_valid_i & ~rx_frame_i.is_cmd & enable;
   wire bad_frame = ~rx_frame_i.len_ok | ~rx_frame_i.etx_ok;
   wire status_q  = rx_frame_i.code == fpisc_pkg::CMD_STATUS;
   wire busy      = state != fpisc_pkg::S_IDLE;
   // checksum range decode
   wire [23:0] sa = {rx_frame_i.prm[0], rx_frame_i.prm[1],
                     rx_frame_i.prm[2]};
   wire [23:0] ea = {rx_frame_i.prm[3], rx_frame_i.prm[4],
                     rx_frame_i.prm[5]};
   wire range_ok  = (sa[fpisc_pkg::BLK_BITS-1:0] == '0) &
                    (&ea[fpisc_pkg::BLK_BITS-1:0]) & (ea >= sa);
   // security data decode
   wire [7:0]  new_flg  = rx_frame_i.prm[0] | fpisc_pkg::FLG_FORCED;
   wire [7:0]  new_boot = rx_frame_i.prm[1];
   wire [23:0] new_vec  = {rx_frame_i.prm[2], rx_frame_i.prm[3],
                           rx_frame_i.prm[4]};
   wire boot_locked = ~cur_flg[fpisc_pkg::BOOT_WR_BIT];
   wire prot_err    = (|(cur_flg & ~new_flg)) |
                      (boot_locked & (new_boot != cur_boot));
   wire param_err   = (new_boot > fpisc_pkg::LAST_BLOCK) |
                      (new_vec != 24'h00_0000);
   wire csum_last   = fl_addr_o == end_addr;
   wire wr_expired  = timer == 32'(SEC_WR_CYC - 1);
   // write fault to status code
   function automatic logic [7:0] fault_code(input logic [1:0] f);
      fault_code = (f == 2'h0) ? fpisc_pkg::ST_ACK :
                   (f == 2'h1) ? fpisc_pkg::ST_ERASE :
                   (f == 2'h2) ? fpisc_pkg::ST_VERIFY : fpisc_pkg::ST_WRITE;
   endfunction
   // sequencer: next state and status answer
   always_comb begin
      next_state    = state;
      next_st_valid = 1'b0;
      next_st_code  = tx_stat_code_o;
      next_sec_wr   = 1'b0;
      next_csum_go  = 1'b0;
      sec_ok        = 1'b0;
      if (cmd_in && status_q && !bad_frame) begin
         next_st_valid = 1'b1;
         next_st_code  = last_code;
      end else if (cmd_in && busy) begin
         next_st_valid = 1'b1;
         next_st_code  = fpisc_pkg::ST_NACK;
      end else if (cmd_in) begin
         next_st_valid = 1'b1;
         if (bad_frame) begin
            next_st_code = fpisc_pkg::ST_NACK;
         end else if (!rx_frame_i.sum_ok) begin
            next_st_code = fpisc_pkg::ST_SUMERR;
         end else begin
            unique case (rx_frame_i.code)
               fpisc_pkg::CMD_VERSION: begin
                  next_st_code = fpisc_pkg::ST_ACK;
                  next_state   = fpisc_pkg::S_VER_DATA;
               end
               fpisc_pkg::CMD_CHECKSUM: begin
                  if (range_ok) begin
                     next_st_code = fpisc_pkg::ST_ACK;
                     next_state   = fpisc_pkg::S_CSUM_RUN;
                     next_csum_go = 1'b1;
                  end else begin
                     next_st_code = fpisc_pkg::ST_PARAM;
                  end
               end
               fpisc_pkg::CMD_SECURITY: begin
                  next_st_code = fpisc_pkg::ST_ACK;
                  next_state   = fpisc_pkg::S_SEC_WAIT;
               end
               default: next_st_code = fpisc_pkg::ST_CMDERR;
            endcase
         end
      end else begin
         unique case (state)
            fpisc_pkg::S_IDLE: ;
            fpisc_pkg::S_VER_DATA: next_state = fpisc_pkg::S_IDLE;
            fpisc_pkg::S_CSUM_RUN:
               if (csum_last) next_state = fpisc_pkg::S_CSUM_TL;
            fpisc_pkg::S_CSUM_TL: next_state = fpisc_pkg::S_CSUM_TX;
            fpisc_pkg::S_CSUM_TX: next_state = fpisc_pkg::S_IDLE;
            fpisc_pkg::S_SEC_WAIT: begin
               if (dat_in) begin
                  next_st_valid = 1'b1;
                  next_state    = fpisc_pkg::S_IDLE;
                  if (bad_frame) begin
                     next_st_code = fpisc_pkg::ST_NACK;
                  end else if (!rx_frame_i.sum_ok) begin
                     next_st_code = fpisc_pkg::ST_SUMERR;
                  end else if (prot_err) begin
                     next_st_code = fpisc_pkg::ST_PROT;
                  end else if (param_err) begin
                     next_st_code = fpisc_pkg::ST_PARAM;
                  end else begin
                     next_st_code = fpisc_pkg::ST_ACK;
                     next_state   = fpisc_pkg::S_SEC_WR;
                     next_sec_wr  = 1'b1;
                  end
               end
            end
            fpisc_pkg::S_SEC_WR: begin
               if (sec_done_i) begin
                  next_st_valid = 1'b1;
                  next_st_code  = fault_code(sec_fault_i);
                  next_state    = fpisc_pkg::S_IDLE;
                  sec_ok        = sec_fault_i == 2'h0;
               end else if (wr_expired) begin
                  next_st_valid = 1'b1;
                  next_st_code  = fpisc_pkg::ST_WRITE;
                  next_state    = fpisc_pkg::S_IDLE;
               end
            end
            default: next_state = fpisc_pkg::S_IDLE;
         endcase
      end
   end
   // state and status frame registers
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         state           <= fpisc_pkg::S_IDLE;
         tx_stat_valid_o <= 1'b0;
         tx_stat_code_o  <= fpisc_pkg::ST_ACK;
         last_code       <= fpisc_pkg::ST_ACK;
         sec_wr_o        <= 1'b0;
      end else begin
         state           <= next_state;
         tx_stat_valid_o <= next_st_valid;
         tx_stat_code_o  <= next_st_code;
         sec_wr_o        <= next_sec_wr;
         if (next_st_valid) last_code <= next_st_code;
      end
   end
   // flash read walk and byte sum
   assign fl_rd_o = state == fpisc_pkg::S_CSUM_RUN;
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         fl_addr_o <= 24'h00_0000;
         end_addr  <= 24'h00_0000;
         sum       <= 16'h0000;
         rd_pend   <= 1'b0;
      end else begin
         rd_pend <= fl_rd_o;
         if (next_csum_go) begin
            fl_addr_o <= sa;
            end_addr  <= ea;
            sum       <= 16'h0000;
         end else begin
            if (fl_rd_o && !csum_last) fl_addr_o <= fl_addr_o + 24'h00_0001;
            if (rd_pend) sum <= sum + {8'h00, fl_rdata_i};
         end
      end
   end
   // data frames: version bytes or checksum high then low
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         tx_data_valid_o <= 1'b0;
         tx_data_o       <= '0;
      end else begin
         tx_data_valid_o <= 1'b0;
         if (state == fpisc_pkg::S_VER_DATA) begin
            tx_data_valid_o <= 1'b1;
            tx_data_o <= {fpisc_pkg::VER_LEN, version, 16'h0000};
         end else if (state == fpisc_pkg::S_CSUM_TX) begin
            tx_data_valid_o <= 1'b1;
            tx_data_o <= {fpisc_pkg::SUM_LEN, sum, 32'h0000_0000};
         end
      end
   end
   // security write request and write watchdog
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         sec_flg_o  <= fpisc_pkg::FLG_RESET;
         sec_boot_o <= fpisc_pkg::BOOT_RESET;
         cur_flg    <= fpisc_pkg::FLG_RESET;
         cur_boot   <= fpisc_pkg::BOOT_RESET;
         timer      <= 32'h0000_0000;
      end else begin
         if (next_sec_wr) begin
            sec_flg_o  <= new_flg;
            sec_boot_o <= new_boot;
         end
         if (sec_ok) begin
            cur_flg  <= sec_flg_o;
            cur_boot <= sec_boot_o;
         end
         if (state == fpisc_pkg::S_SEC_WR && next_state == state)
            timer <= timer + 32'h0000_0001;
         else timer <= 32'h0000_0000;
      end
   end
   // interrupt events, read of status clears, set wins
   wire       irq_rd = rd_i & (addr_i == fpisc_pkg::REG_IRQ);
   wire       ack_ev = next_st_valid & (next_st_code == fpisc_pkg::ST_ACK);
   wire       err_ev = next_st_valid & (next_st_code != fpisc_pkg::ST_ACK);
   assign irq_o = |(irq_stat & irq_mask);
   // register writes
   always_ff @(posedge core_clk_i) begin
      if (reset_i) begin
         enable   <= 1'b0;
         irq_mask <= 3'h0;
         irq_stat <= 3'h0;
         version  <= fpisc_pkg::VERSION_RESET;
      end else begin
         irq_stat <= (irq_rd ? 3'h0 : irq_stat) | {sec_ok, err_ev, ack_ev};
         if (wr_i && addr_i == fpisc_pkg::REG_CTRL) enable <= wdata_i[0];
         if (wr_i && addr_i == fpisc_pkg::REG_MASK) irq_mask <= wdata_i[2:0];
         if (wr_i && addr_i == fpisc_pkg::REG_VERSION) version <= wdata_i;
      end
   end
   // register read mux, unmapped reads zero
   logic [31:0] rd_mux;
   always_comb begin
      unique case (addr_i)
         fpisc_pkg::REG_CTRL:    rd_mux = {31'h0, enable};
         fpisc_pkg::REG_IRQ:     rd_mux = {29'h0, irq_stat};
         fpisc_pkg::REG_MASK:    rd_mux = {29'h0, irq_mask};
         fpisc_pkg::REG_VERSION: rd_mux = version;
         fpisc_pkg::REG_SECST:   rd_mux = {16'h0000, cur_boot, cur_flg};
         fpisc_pkg::REG_LAST:    rd_mux = {24'h00_0000, last_code};
         default:                rd_mux = 32'h0000_0000;
      endcase
   end
   always_ff @(posedge core_clk_i) begin
      if (reset_i) rdata_o <= 32'h0000_0000;
      else rdata_o <= rd_i ? rd_mux : 32'h0000_0000;
   end
   // checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   wire cmd_new = cmd_in & ~busy & ~status_q;
   a_busy_nack: assert property (
      (cmd_in && busy && !status_q) |=>
         tx_stat_valid_o && tx_stat_code_o == fpisc_pkg::ST_NACK)
      else $error("busy command not refused");
   a_frame_nack: assert property (
      (cmd_new && bad_frame) |=> tx_stat_code_o == fpisc_pkg::ST_NACK)
      else $error("malformed command not refused");
   a_cmd_sum: assert property (
      (cmd_new && !bad_frame && !rx_frame_i.sum_ok) |=>
         tx_stat_code_o == fpisc_pkg::ST_SUMERR)
      else $error("command checksum error missed");
   a_version_seq: assert property (
      (cmd_new && !bad_frame && rx_frame_i.sum_ok &&
       rx_frame_i.code == fpisc_pkg::CMD_VERSION) |=>
         tx_stat_code_o == fpisc_pkg::ST_ACK ##1
         tx_data_valid_o && tx_data_o.len == fpisc_pkg::VER_LEN)
      else $error("version answer wrong");
   a_range_err: assert property (
      (cmd_new && !bad_frame && rx_frame_i.sum_ok && !range_ok &&
       rx_frame_i.code == fpisc_pkg::CMD_CHECKSUM) |=>
         tx_stat_code_o == fpisc_pkg::ST_PARAM && state == fpisc_pkg::S_IDLE)
      else $error("unaligned range accepted");
   a_sec_prot: assert property (
      (state == fpisc_pkg::S_SEC_WAIT && dat_in && !bad_frame &&
       rx_frame_i.sum_ok && prot_err) |=>
         tx_stat_code_o == fpisc_pkg::ST_PROT && !sec_wr_o)
      else $error("protect error missed");
   a_sec_param: assert property (
      (state == fpisc_pkg::S_SEC_WAIT && dat_in && !bad_frame &&
       rx_frame_i.sum_ok && !prot_err && param_err) |=>
         tx_stat_code_o == fpisc_pkg::ST_PARAM)
      else $error("security parameter error missed");
   a_sec_malformed: assert property (
      (state == fpisc_pkg::S_SEC_WAIT && dat_in && bad_frame) |=>
         tx_stat_code_o == fpisc_pkg::ST_NACK && !sec_wr_o)
      else $error("malformed security data accepted");
   a_write_fault: assert property (
      (state == fpisc_pkg::S_SEC_WR && !cmd_in && sec_done_i &&
       sec_fault_i == 2'h1) |=>
         tx_stat_valid_o && tx_stat_code_o == fpisc_pkg::ST_ERASE)
      else $error("erase fault not reported");
   a_write_bound: assert property (
      timer < SEC_WR_CYC)
      else $error("security write overran time-out");
endmodule // fpisc_top

/* fpisc_unused_guard.sv */
// no further design content
`timescale 1ns/10ps

/* fpisc_prog_model.sv */
// programmer, flash array and security writer stand-in
`timescale 1ns/10ps
module fpisc_prog_model #(
   parameter int GAP = 4
) (
   input  wire logic            clk_i,
   input  wire logic            fl_rd_i,
   input  wire logic [23:0]     fl_addr_i,
   output logic      [7:0]      fl_rdata_o,
   input  wire logic            sec_wr_i,
   output logic                 sec_done_o,
   output logic      [1:0]      sec_fault_o,
   output logic                 rx_valid_o,
   output fpisc_pkg::fpisc_rx_t rx_frame_o
);
   int         delay;
   int         cnt;
   logic [1:0] fault;
   // quiet outputs at time zero
   initial begin
      delay = 5;
      cnt = 0;
      fault = 2'h0;
      fl_rdata_o = 8'h00;
      sec_done_o = 1'b0;
      sec_fault_o = 2'h3;
      rx_valid_o = 1'b0;
      rx_frame_o = '0;
   end
   // flash byte for last cycle's address, toggling when not read
   always @(posedge clk_i) begin
      if (fl_rd_i)
         fl_rdata_o <= fl_addr_i[7:0] ^ fl_addr_i[15:8];
      else
         fl_rdata_o <= ~fl_rdata_o;
   end
   // write engine: done after delay cycles, never when delay is 0
   always @(posedge clk_i) begin
      sec_done_o <= 1'b0;
      sec_fault_o <= ~fault;
      if (sec_wr_i && delay != 0)
         cnt <= delay;
      else if (cnt == 1) begin
         sec_done_o <= 1'b1;
         sec_fault_o <= fault;
         cnt <= 0;
      end else if (cnt > 1)
         cnt <= cnt - 1;
   end
   // one frame after the gap, then lines scrambled
   task automatic send(input logic c, input logic [7:0] code,
                       input logic [2:0] ok, input logic [5:0][7:0] p);
      repeat (GAP) @(posedge clk_i);
      rx_valid_o <= 1'b1;
      rx_frame_o <= '{c, code, ok[2], ok[1], ok[0], p};
      @(posedge clk_i);
      rx_valid_o <= 1'b0;
      rx_frame_o <= ~rx_frame_o;
   endtask
endmodule // fpisc_prog_model

/* fpisc_top_tb.sv */
// self-checking bench for the flash command interpreter
`timescale 1ns/10ps
module fpisc_top_tb;
   logic                  clk;
   logic                  rst;
   logic                  wr;
   logic                  rd;
   logic [7:0]            addr;
   logic [31:0]           wdata;
   logic [31:0]           rdata;
   logic                  irq;
   logic                  rx_valid;
   fpisc_pkg::fpisc_rx_t  rx_frame;
   logic                  stat_v;
   logic [7:0]            stat_code;
   logic                  data_v;
   fpisc_pkg::fpisc_txd_t txd;
   logic                  fl_rd;
   logic [23:0]           fl_addr;
   logic [7:0]            fl_rdata;
   logic                  sec_wr;
   logic [7:0]            sec_flg;
   logic [7:0]            sec_boot;
   logic                  sec_done;
   logic [1:0]            sec_fault;
   int                    failures;
   int                    n_compared;
   logic [7:0]            wr_code [4];

   // 25 MHz clock
   initial clk = 1'b0;
   always #20 clk = ~clk;

   fpisc_top #(.SEC_WR_CYC(50)) dut (
      .core_clk_i(clk), .reset_i(rst), .addr_i(addr), .wdata_i(wdata),
      .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .irq_o(irq),
      .rx_valid_i(rx_valid), .rx_frame_i(rx_frame),
      .tx_stat_valid_o(stat_v), .tx_stat_code_o(stat_code),
      .tx_data_valid_o(data_v), .tx_data_o(txd), .fl_rd_o(fl_rd),
      .fl_addr_o(fl_addr), .fl_rdata_i(fl_rdata), .sec_wr_o(sec_wr),
      .sec_flg_o(sec_flg), .sec_boot_o(sec_boot),
      .sec_done_i(sec_done), .sec_fault_i(sec_fault));

   fpisc_prog_model m (
      .clk_i(clk), .fl_rd_i(fl_rd), .fl_addr_i(fl_addr),
      .fl_rdata_o(fl_rdata), .sec_wr_i(sec_wr), .sec_done_o(sec_done),
      .sec_fault_o(sec_fault), .rx_valid_o(rx_valid),
      .rx_frame_o(rx_frame));

   // verdict and end of run
   task automatic test_done();
      $display("compared %0d mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] exp,
                        input logic [31:0] got);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic give_up(input string what);
      failures++;
      $display("[FAIL] %s expected pulse seen none", what);
      test_done();
   endtask
   // register bus cycles
   task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      check("rdata", exp, rdata);
   endtask
   // bounded waits for answers from the device
   task automatic wait_stat(input logic [7:0] exp);
      int i;
      for (i = 0; i < 300; i++) begin
         @(negedge clk);
         if (stat_v === 1'b1) break;
      end
      if (i == 300) give_up("status");
      check("status", {24'h00_0000, exp}, {24'h00_0000, stat_code});
   endtask
   task automatic wait_data(input logic [2:0] len, input logic [31:0] exp);
      int i;
      for (i = 0; i < 3000; i++) begin
         @(negedge clk);
         if (data_v === 1'b1) break;
      end
      if (i == 3000) give_up("data frame");
      check("data len", {29'h0, len}, {29'h0, txd.len});
      if (len == fpisc_pkg::VER_LEN)
         check("version", exp, txd.pld[5:2]);
      else
         check("sum", exp, {16'h0000, txd.pld[5:4]});
   endtask
   task automatic cmd(input logic c, input logic [7:0] code,
                      input logic [2:0] ok, input logic [47:0] p,
                      input logic [7:0] exp);
      m.send(c, code, ok, p);
      wait_stat(exp);
   endtask
   task automatic sec(input logic [7:0] f, input logic [7:0] b,
                      input logic [23:0] v, input logic [2:0] ok,
                      input logic [7:0] exp);
      cmd(1'b1, fpisc_pkg::CMD_SECURITY, 3'h7, 48'h0, 8'h06);
      // no data frame unless the command was acknowledged
      if (stat_code === fpisc_pkg::ST_ACK)
         cmd(1'b0, 8'h00, ok, {8'h00, v[7:0], v[15:8], v[23:16], b, f},
             exp);
   endtask
   // byte sum of the flash stand-in over the first n bytes
   function automatic logic [15:0] flash_sum(input int n);
      logic [15:0] s;
      s = 16'h0000;
      for (int a = 0; a < n; a++)
         s = s + {8'h00, a[7:0] ^ a[15:8]};
      return s;
   endfunction

   // main sequence
   initial begin
      rst = 1'b1;
      wr = 1'b0;
      rd = 1'b0;
      addr = 8'h00;
      wdata = 32'h0000_0000;
      failures = 0;
      n_compared = 0;
      wr_code = '{8'h06, 8'h1A, 8'h1B, 8'h1C};
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      reg_rd(fpisc_pkg::REG_VERSION, 32'h0000_0000);
      reg_rd(fpisc_pkg::REG_LAST, 32'h0000_0006);
      reg_rd(8'h20, 32'h0000_0000);
      reg_wr(fpisc_pkg::REG_SECST, 32'hFFFF_0000);
      reg_rd(fpisc_pkg::REG_SECST, 32'h0000_00FF);
      m.send(1'b1, fpisc_pkg::CMD_VERSION, 3'h7, 48'h0);
      @(negedge clk);
      check("idle status", 32'h0, {31'h0, stat_v});
      reg_wr(fpisc_pkg::REG_CTRL, 32'h0000_0001);
      reg_wr(fpisc_pkg::REG_VERSION, 32'h1234_5678);
      reg_wr(fpisc_pkg::REG_MASK, 32'h0000_0000);
      cmd(1'b1, fpisc_pkg::CMD_VERSION, 3'h7, 48'h0, 8'h06);
      wait_data(3'h4, 32'h1234_5678);
      check("irq masked", 32'h0, {31'h0, irq});
      reg_wr(fpisc_pkg::REG_MASK, 32'h0000_0001);
      @(negedge clk);
      check("irq", 32'h1, {31'h0, irq});
      reg_rd(fpisc_pkg::REG_IRQ, 32'h0000_0001);
      check("irq cleared", 32'h0, {31'h0, irq});
      reg_wr(fpisc_pkg::REG_MASK, 32'h0000_0007);
      cmd(1'b1, fpisc_pkg::CMD_VERSION, 3'h6, 48'h0, 8'h07);
      cmd(1'b1, fpisc_pkg::CMD_VERSION, 3'h3, 48'h0, 8'h15);
      cmd(1'b1, fpisc_pkg::CMD_VERSION, 3'h5, 48'h0, 8'h15);
      cmd(1'b1, 8'h11, 3'h7, 48'h0, 8'h04);
      cmd(1'b1, 8'hB0, 3'h7, 48'hFF07_0001_0000, 8'h05);
      cmd(1'b1, 8'hB0, 3'h7, 48'hFE07_0000_0000, 8'h05);
      cmd(1'b1, fpisc_pkg::CMD_STATUS, 3'h7, 48'h0, 8'h05);
      cmd(1'b1, 8'hB0, 3'h7, 48'hFF07_0000_0000, 8'h06);
      cmd(1'b1, fpisc_pkg::CMD_VERSION, 3'h7, 48'h0, 8'h15);
      wait_data(3'h2, {16'h0000, flash_sum(2048)});
      sec(8'hFF, 8'h05, 24'h00_0100, 3'h7, 8'h05);
      sec(8'hFF, 8'h80, 24'h00_0000, 3'h7, 8'h05);
      sec(8'hEF, 8'h00, 24'h00_0000, 3'h7, 8'h10);
      sec(8'hFF, 8'h00, 24'h00_0000, 3'h3, 8'h15);
      sec(8'hFF, 8'h00, 24'h00_0000, 3'h6, 8'h07);
      for (int k = 0; k < 4; k++) begin
         m.fault = 2'(k);
         sec(8'h1F, 8'h05, 24'h00_0000, 3'h7, 8'h06);
         check("flag", 32'h0000_00FF, {24'h00_0000, sec_flg});
         check("boot", 32'h0000_0005, {24'h00_0000, sec_boot});
         wait_stat(wr_code[k]);
      end
      reg_rd(fpisc_pkg::REG_SECST, 32'h0000_05FF);
      m.delay = 0;
      sec(8'hFF, 8'h05, 24'h00_0000, 3'h7, 8'h06);
      wait_stat(8'h1C);
      reg_rd(fpisc_pkg::REG_LAST, 32'h0000_001C);
      check("irq", 32'h1, {31'h0, irq});
      reg_rd(fpisc_pkg::REG_IRQ, 32'h0000_0007);
      check("irq cleared", 32'h0, {31'h0, irq});
      test_done();
   end
endmodule // fpisc_top_tb
